// ---- hdl/fndc_top.sv ----
// Fractional-N divider configuration: serial loader, reference and feedback dividers
// Behaviour
// - Mode bit one selects differential reference buffer
// - PFD clock is ref times doubler over R-halver
// - Ten-bit reference counter divides by 1 to 1023
// - Feedback ratio is INT plus combined fractions
// - Main numerator 24 bits, modulus fixed 2^24
// - Aux numerator 0..16383, aux modulus 2..16383; the code stores any 14-bit modulus, 0 and 1 included
// - Zero numerators give integer-N mode
// - Oscillator settles at PFD times feedback ratio
// - Aux modulus gives exact spacing, else 38-bit
// - 32-bit words MSB first, low 4 bits select register
// - Buffered settings apply on register zero write
`timescale 1ns/1ps
`include "fndc_defs.svh"
module fndc_top
    import fndc_pkg::*;
#(
    parameter int R_W = `FNDC_R_W
) (
    // Clock, reset, enable
    input  wire logic             CORE_CLK,
    input  wire logic             RSTN,
    input  wire logic             CLK_EN,
    // Three-wire serial interface, sampled on CORE_CLK
    input  wire logic             SER_CLK,
    input  wire logic             SER_DATA,
    input  wire logic             LOAD_STROBE,
    // Reference path
    input  wire logic             REF_IN,
    output logic                  REF_DIFF_EN,
    output logic                  PFD_CLK,
    // Feedback path
    output logic [`FNDC_INT_W:0]  FB_DIVIDE,
    output logic                  INT_N_MODE,
    output logic                  PRESCALER_89,
    output logic [`FNDC_CP_W-1:0] PUMP_CURRENT
);
    logic rst_meta_reg, rst_n;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // Serial shift register, edges detected on the sampled pins
    logic [`FNDC_WORD_W-1:0] shift_reg;
    logic                    sclk_d_reg, le_d_reg;
    wire                     sclk_rise = SER_CLK & ~sclk_d_reg;
    wire                     le_rise   = LOAD_STROBE & ~le_d_reg;
    wire [`FNDC_ADDR_W-1:0]  addr      = shift_reg[`FNDC_ADDR_W-1:0];
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg  <= '0;
            sclk_d_reg <= 1'b0;
            le_d_reg   <= 1'b0;
        end else if (CLK_EN) begin
            sclk_d_reg <= SER_CLK;
            le_d_reg   <= LOAD_STROBE;
            if (sclk_rise)
                shift_reg <= {shift_reg[`FNDC_WORD_W-2:0], SER_DATA};
        end
    end

    // Pending and active settings
    fndc_buf_t              pend_reg, act_reg;
    logic [`FNDC_INT_W-1:0] int_reg;
    logic                   pre89_reg, refmode_reg;
    wire                    wr = CLK_EN & le_rise;
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            int_reg     <= `FNDC_INT_RESET;
            pre89_reg   <= 1'b1;
            refmode_reg <= 1'b0;
            pend_reg    <= '{default: '0, aux_modulus: `FNDC_M2_RESET, ref_count: `FNDC_R_RESET};
        end else if (wr) begin
            case (addr)
                `FNDC_REG0: begin
                    int_reg   <= shift_reg[`FNDC_INT_LSB +: `FNDC_INT_W];
                    pre89_reg <= shift_reg[`FNDC_PRE_BIT];
                end
                `FNDC_REG1: pend_reg.main_fraction_numerator <= shift_reg[`FNDC_F1_LSB +: `FNDC_F1_W];
                `FNDC_REG2: begin
                    pend_reg.aux_fraction_numerator <= shift_reg[`FNDC_F2_LSB +: `FNDC_F2_W];
                    pend_reg.aux_modulus            <= shift_reg[`FNDC_M2_LSB +: `FNDC_F2_W];
                end
                `FNDC_REG4: begin
                    refmode_reg               <= shift_reg[`FNDC_REFMODE_BIT];
                    pend_reg.pump_current     <= shift_reg[`FNDC_CP_LSB +: `FNDC_CP_W];
                    pend_reg.reference_halver <= shift_reg[`FNDC_HALF_BIT];
                    pend_reg.doubler          <= shift_reg[`FNDC_DBL_BIT];
                    pend_reg.ref_count        <= shift_reg[`FNDC_R_LSB +: `FNDC_R_W];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n)
            act_reg <= '{default: '0, aux_modulus: `FNDC_M2_RESET, ref_count: `FNDC_R_RESET};
        else if (wr && addr == `FNDC_REG0)
            act_reg <= pend_reg;
    end

    assign REF_DIFF_EN  = refmode_reg;
    assign PRESCALER_89 = pre89_reg;
    assign PUMP_CURRENT = act_reg.pump_current;

    // Reference path: doubler uses both edges as count events, halver toggles
    logic             ref_d_reg, half_reg, pfd_reg;
    logic [R_W-1:0]   rcnt_reg;
    wire              ref_ev  = act_reg.doubler ? (REF_IN ^ ref_d_reg) : (REF_IN & ~ref_d_reg);
    wire  [R_W-1:0]   r_ratio = (act_reg.ref_count == '0) ? R_W'(1) : R_W'(act_reg.ref_count);
    wire              r_tc    = ref_ev && (rcnt_reg >= r_ratio - R_W'(1));
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ref_d_reg <= 1'b0;
            rcnt_reg  <= '0;
            half_reg  <= 1'b0;
            pfd_reg   <= 1'b0;
        end else if (CLK_EN) begin
            ref_d_reg <= REF_IN;
            pfd_reg   <= 1'b0;
            if (ref_ev)
                rcnt_reg <= r_tc ? '0 : rcnt_reg + R_W'(1);
            if (r_tc) begin
                half_reg <= ~half_reg;
                pfd_reg  <= ~act_reg.reference_halver | half_reg;
            end
        end
    end
    assign PFD_CLK = pfd_reg;

    // Two-stage accumulator: aux over aux modulus carries into main over 2^24
    logic [`FNDC_F2_W-1:0] acc2_reg;
    logic [`FNDC_F1_W:0]   acc1_reg;
    logic [`FNDC_INT_W:0]  fb_reg;
    wire  [`FNDC_F2_W:0]   sum2  = {1'b0, acc2_reg} + {1'b0, act_reg.aux_fraction_numerator};
    wire                   c2    = sum2 >= {1'b0, act_reg.aux_modulus};
    wire  [`FNDC_F1_W:0]   sum1  = {1'b0, acc1_reg[`FNDC_F1_W-1:0]}
                                   + {1'b0, act_reg.main_fraction_numerator} + {{`FNDC_F1_W{1'b0}}, c2};
    wire                   int_n = (act_reg.main_fraction_numerator == '0) &&
                                   (act_reg.aux_fraction_numerator == '0);
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            acc2_reg <= '0;
            acc1_reg <= '0;
            fb_reg   <= {1'b0, `FNDC_INT_RESET};
        end else if (CLK_EN && pfd_reg) begin
            if (int_n) begin
                acc2_reg <= '0;
                acc1_reg <= '0;
                fb_reg   <= {1'b0, int_reg};
            end else begin
                acc2_reg <= c2 ? `FNDC_F2_W'(sum2 - {1'b0, act_reg.aux_modulus}) : sum2[`FNDC_F2_W-1:0];
                acc1_reg <= sum1;
                fb_reg   <= {1'b0, int_reg} + {{`FNDC_INT_W{1'b0}}, sum1[`FNDC_F1_W]};
            end
        end
    end
    assign FB_DIVIDE  = fb_reg;
    assign INT_N_MODE = int_n;

    // Steps of a load and of a phase detector tick
    sequence reg0_write_s;
        wr && addr == `FNDC_REG0;
    endsequence
    sequence reg4_write_s;
        wr && addr == `FNDC_REG4;
    endsequence
    sequence pfd_tick_s;
        CLK_EN && pfd_reg;
    endsequence

    load_apply_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        reg0_write_s |=> act_reg == $past(pend_reg))
        else $error("buffered settings not applied on register zero");
    hold_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        !(wr && addr == `FNDC_REG0) |=> act_reg == $past(act_reg))
        else $error("buffered settings changed without register zero");
    fb_step_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        pfd_tick_s |=> FB_DIVIDE == {1'b0, $past(int_reg)} || FB_DIVIDE == {1'b0, $past(int_reg)} + 17'h1)
        else $error("feedback divide not adjacent to integer");
    int_mode_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        pfd_tick_s ##0 int_n |=> FB_DIVIDE == {1'b0, $past(int_reg)})
        else $error("integer mode divide wrong");
    shift_in_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        CLK_EN && sclk_rise |=> shift_reg[0] == $past(SER_DATA))
        else $error("serial bit not shifted in");
    refmode_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        reg4_write_s |=> REF_DIFF_EN == $past(shift_reg[`FNDC_REFMODE_BIT]))
        else $error("reference mode not taken");
    pfd_pulse_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        PFD_CLK && $past(CLK_EN) |-> $past(r_tc))
        else $error("pfd pulse without reference terminal count");
    rcnt_range_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        CLK_EN && ref_ev |=> rcnt_reg < $past(r_ratio))
        else $error("reference counter out of range");
    prescaler_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        reg0_write_s |=> PRESCALER_89 == $past(shift_reg[`FNDC_PRE_BIT]))
        else $error("prescaler bit not taken");
    pump_apply_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        reg0_write_s |=> PUMP_CURRENT == $past(pend_reg.pump_current))
        else $error("pump current not applied on register zero");
    shift_hold_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        !(CLK_EN && sclk_rise) |=> shift_reg == $past(shift_reg))
        else $error("shift register moved without a serial clock edge");
    unmapped_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        wr && addr != `FNDC_REG0 && addr != `FNDC_REG1 && addr != `FNDC_REG2 && addr != `FNDC_REG4 |=>
        pend_reg == $past(pend_reg) && int_reg == $past(int_reg) && refmode_reg == $past(refmode_reg))
        else $error("unmapped address changed a setting");
    freeze_a: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        !CLK_EN |=> pfd_reg == $past(pfd_reg) && rcnt_reg == $past(rcnt_reg) && fb_reg == $past(fb_reg))
        else $error("dividers moved while enable low");
endmodule

// ---- pkg/fndc_defs.svh ----
// Constants for the fractional-N divider configuration block
`ifndef FNDC_DEFS_SVH
`define FNDC_DEFS_SVH
`define FNDC_WORD_W      32
`define FNDC_ADDR_W      4
`define FNDC_NREGS       13
`define FNDC_R_W         10
`define FNDC_INT_W       16
`define FNDC_F1_W        24
`define FNDC_F2_W        14
`define FNDC_CP_W        4
`define FNDC_REG0        4'h0
`define FNDC_REG1        4'h1
`define FNDC_REG2        4'h2
`define FNDC_REG4        4'h4
`define FNDC_INT_LSB     4
`define FNDC_PRE_BIT     20
`define FNDC_F1_LSB      4
`define FNDC_F2_LSB      18
`define FNDC_M2_LSB      4
`define FNDC_REFMODE_BIT 9
`define FNDC_CP_LSB      10
`define FNDC_HALF_BIT    14
`define FNDC_DBL_BIT     15
`define FNDC_R_LSB       16
`define FNDC_R_RESET     10'h001
`define FNDC_M2_RESET    14'h0002
`define FNDC_INT_RESET   16'h004b
`endif

// ---- pkg/fndc_pkg.sv ----
// Types for the fractional-N divider configuration block
`include "fndc_defs.svh"
package fndc_pkg;
    typedef struct packed {
        logic [`FNDC_F1_W-1:0] main_fraction_numerator;
        logic [`FNDC_F2_W-1:0] aux_modulus;
        logic [`FNDC_F2_W-1:0] aux_fraction_numerator;
        logic                  doubler;
        logic                  reference_halver;
        logic [`FNDC_R_W-1:0]  ref_count;
        logic [`FNDC_CP_W-1:0] pump_current;
    } fndc_buf_t;
    typedef enum logic [1:0] {
        FNDC_IDLE  = 2'b00,
        FNDC_SHIFT = 2'b01,
        FNDC_LOAD  = 2'b10
    } fndc_state_t;
endpackage

// ---- sim/fndc_host.sv ----
// Host model that loads words over the three-wire serial interface
`timescale 1ns/1ps
module fndc_host (
    // Clock
    input  wire logic clk,
    // Serial lines
    output logic      ser_clk,
    output logic      ser_data,
    output logic      load_strobe
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b1;
        load_strobe = 1'b0;
    end
    // Word goes out MSB first; the data line flips once its hold is over
    task automatic send(input logic [31:0] word);
        for (int i = 31; i >= 0; i--) begin
            @(negedge clk) ser_data = word[i];
            repeat (2) @(negedge clk);
            ser_clk = 1'b1;
            repeat (2) @(negedge clk);
            ser_clk = 1'b0;
            ser_data = ~word[i];
        end
        @(negedge clk) load_strobe = 1'b1;
        repeat (2) @(negedge clk);
        load_strobe = 1'b0;
        repeat (2) @(negedge clk);
    endtask
endmodule

// ---- sim/tb_fndc_top.sv ----
// Self-checking testbench for the fractional-N divider configuration block
`timescale 1ns/1ps
module tb_fndc_top;
    logic        core_clk, rstn, clk_en, ref_in, ser_clk, ser_data, load_strobe;
    logic        ref_diff_en, pfd_clk, int_n_mode, prescaler_89;
    logic [16:0] fb_divide;
    logic [3:0]  pump_current;
    int          errors, num_checks, sum, p;
    int          tbl[4][3] = '{'{0, 0, 24}, '{1, 0, 12}, '{0, 1, 48}, '{1, 1, 24}};

    fndc_top fndc_top_inst (.CORE_CLK(core_clk), .RSTN(rstn), .CLK_EN(clk_en), .SER_CLK(ser_clk),
        .SER_DATA(ser_data), .LOAD_STROBE(load_strobe), .REF_IN(ref_in), .REF_DIFF_EN(ref_diff_en),
        .PFD_CLK(pfd_clk), .FB_DIVIDE(fb_divide), .INT_N_MODE(int_n_mode),
        .PRESCALER_89(prescaler_89), .PUMP_CURRENT(pump_current));
    fndc_host fndc_host_inst (.clk(core_clk), .ser_clk(ser_clk), .ser_data(ser_data),
        .load_strobe(load_strobe));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Reference toggles every 4 core cycles
    always begin
        repeat (4) @(negedge core_clk);
        ref_in = ~ref_in;
    end

    function automatic logic [31:0] r0(input logic [15:0] n);
        return {11'h000, 1'b1, n, 4'h0};
    endfunction
    // Count 3, pump current 5, differential mode
    function automatic logic [31:0] r4(input logic d, input logic h);
        return {6'h00, 10'h003, d, h, 4'h5, 1'b1, 5'h00, 4'h4};
    endfunction
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: got %0d expected %0d", $time, got, exp);
        end
    endtask
    // Cycles from one phase detector pulse to the next
    task automatic period(output int n);
        repeat (3) begin
            n = 0;
            do begin
                @(negedge core_clk);
                n++;
            end while (pfd_clk !== 1'b1 && n < 400);
        end
    endtask
    // Sum of the divide counts over eight phase detector cycles
    task automatic fb_sum(output int s);
        s = 0;
        repeat (8) begin
            do @(negedge core_clk); while (pfd_clk !== 1'b1);
            @(negedge core_clk);
            s += int'(fb_divide);
        end
    endtask
    task finish_test;
        $display("Checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #2000000;
        errors++;
        finish_test;
    end
    initial begin
        rstn = 1'b0;
        clk_en = 1'b1;
        ref_in = 1'b0;
        errors = 0;
        num_checks = 0;
        repeat (6) @(negedge core_clk);
        rstn = 1'b1;
        repeat (3) @(negedge core_clk);
        check(fb_divide, 17'h0004b);
        check({16'h0000, int_n_mode}, 17'h00001);
        check({16'h0000, ref_diff_en}, 17'h00000);
        check({16'h0000, prescaler_89}, 17'h00001);
        fndc_host_inst.send(r4(1'b0, 1'b0));
        check({16'h0000, ref_diff_en}, 17'h00001);
        check({13'h0000, pump_current}, 17'h00000);
        fndc_host_inst.send(r0(16'h0064));
        check({13'h0000, pump_current}, 17'h00005);
        for (int i = 0; i < 4; i++) begin
            fndc_host_inst.send(r4(tbl[i][0][0], tbl[i][1][0]));
            fndc_host_inst.send(r0(16'h0064));
            period(p);
            check(17'(p), 17'(tbl[i][2]));
        end
        // Half fraction: N of 100.5 gives one carry every two cycles
        fndc_host_inst.send({4'h0, 24'h800000, 4'h1});
        fndc_host_inst.send(r0(16'h0064));
        check({16'h0000, int_n_mode}, 17'h00000);
        period(p);
        fb_sum(sum);
        check(17'(sum), 17'd804);
        // Enable low freezes the dividers: no pulse, no divide change
        clk_en = 1'b0;
        p = int'(fb_divide);
        sum = 0;
        repeat (60) begin
            @(negedge core_clk);
            if (pfd_clk === 1'b1)
                sum++;
        end
        check(17'(sum), 17'h00000);
        check(fb_divide, 17'(p));
        clk_en = 1'b1;
        period(p);
        check(17'(p), 17'd24);
        fndc_host_inst.send({28'hfffffff, 4'h5});
        check({13'h0000, pump_current}, 17'h00005);
        fndc_host_inst.send({4'h0, 24'h000000, 4'h1});
        fndc_host_inst.send({14'h0001, 14'h0002, 4'h2});
        fndc_host_inst.send(r0(16'h0064));
        check({16'h0000, int_n_mode}, 17'h00000);
        // Aux half step only reaches the main stage's lowest bit
        fb_sum(sum);
        check(17'(sum), 17'd800);
        fndc_host_inst.send({14'h0000, 14'h3fff, 4'h2});
        fndc_host_inst.send(r0(16'h0064));
        check({16'h0000, int_n_mode}, 17'h00001);
        // Integer 50 with the 4/5 prescaler
        fndc_host_inst.send({11'h000, 1'b0, 16'h0032, 4'h0});
        check({16'h0000, prescaler_89}, 17'h00000);
        fb_sum(sum);
        check(17'(sum), 17'd400);
        finish_test;
    end
endmodule
